// [bench/dpo_ctl_model.sv]
`timescale 1ns/10ps
// Controller model: free memory clock, pins move on its falling edge, strobe rises 50 ns after a rise or a fall
module dpo_ctl_model import dpo_pkg::*; (
  // Memory clock and power
  output logic ck_pin,
  output logic cke_pin,
  // Termination and commands
  output logic term_ctl_pin,
  output dpo_cmd_t cmd_pin,
  // Strobe
  output logic dqs_pin,
  output logic dqs_driven_pin
);
  // Pins move half a period before a rise, so they stand across it
  initial begin
    ck_pin = 1'b0;
    cke_pin = 1'b1;
    term_ctl_pin = 1'b0;
    cmd_pin = '0;
    dqs_pin = 1'b0; // Undriven strobe is parked low
    dqs_driven_pin = 1'b0;
    #5;
    forever #100 ck_pin = ~ck_pin;
  end
  // One or two commands, power-down entry n rises after the first
  task pd_after(input dpo_cmd_t c, input dpo_cmd_t c2, input int n);
    @(negedge ck_pin) cmd_pin = c;
    for (int i = 1; i <= n; i++) begin
      @(negedge ck_pin) cmd_pin = (i == 1) ? c2 : '0;
    end
    cke_pin = 1'b0;
    repeat (2) @(negedge ck_pin);
    cke_pin = 1'b1;
    cmd_pin = '0;
  endtask
  // Termination high for n rises, command beside the first
  task term_pulse(input dpo_cmd_t c, input int n);
    @(negedge ck_pin) term_ctl_pin = 1'b1;
    cmd_pin = c;
    @(negedge ck_pin) cmd_pin = '0;
    repeat (n - 1) @(negedge ck_pin);
    term_ctl_pin = 1'b0;
  endtask
  // Plain levels for the frozen power-down case
  task pins(input logic cke, input logic term);
    @(negedge ck_pin) cke_pin = cke;
    term_ctl_pin = term;
  endtask
  // Strobe drivers switch n falls later
  task drive_en(input int n, input logic v);
    repeat (n) @(negedge ck_pin);
    dqs_driven_pin = v;
  endtask
  // Strobe rise n rises on, in the high or the low phase of ck
  task strobe(input logic hi, input int n);
    dqs_pin = 1'b0;
    repeat (n) @(posedge ck_pin);
    if (!hi) @(negedge ck_pin);
    #50 dqs_pin = 1'b1;
  endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/10ps
// Bench: controller model on the pins, ordinary cases in a table
module tb import dpo_pkg::*; ;
  localparam int OFF_LAT = 6;
  // One case: command pair, spacing in ck rises, expected flag
  typedef struct packed {
    logic term;
    dpo_cmd_t c;
    dpo_cmd_t c2;
    logic chop;
    logic [4:0] n;
    logic e;
  } dpo_row_t;
  logic clk;
  logic rst;
  logic ck_pin;
  logic cke_pin;
  logic term_ctl_pin;
  dpo_cmd_t cmd_pin;
  logic dqs_pin;
  logic dqs_driven_pin;
  dpo_cfg_t cfg;
  logic term_on;
  logic level_dq;
  logic level_dq_oe;
  dpo_viol_t viol;
  int n_mismatch;
  int n_tests;
  dpo_row_t rows [19];

  dpo_ctl_model i_dpo_ctl_model (.ck_pin(ck_pin), .cke_pin(cke_pin),
    .term_ctl_pin(term_ctl_pin), .cmd_pin(cmd_pin), .dqs_pin(dqs_pin),
    .dqs_driven_pin(dqs_driven_pin));
  // Recovery of 450 ns against a 200 ns ck rounds up to 3 cycles
  dpo_timing_guard #(.WRITE_RECOVERY_PS(450000),
    .TERM_OFF_LATENCY(OFF_LAT)) i_dpo_timing_guard (.clk(clk), .rst(rst),
    .ck_pin(ck_pin), .cke_pin(cke_pin), .term_ctl_pin(term_ctl_pin),
    .cmd_pin(cmd_pin), .dqs_pin(dqs_pin), .dqs_driven_pin(dqs_driven_pin),
    .cfg_pin(cfg), .term_on(term_on), .level_dq(level_dq),
    .level_dq_oe(level_dq_oe), .viol(viol));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard
  initial begin
    #400000;
    n_mismatch++;
    complete_run;
  end

  task chk(input string name, input logic [3:0] exp, input logic [3:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task complete_run;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Five cycles covers the synchronisers flushing too
  task do_reset;
    @(posedge clk) #2 rst = 1'b1;
    repeat (5) @(posedge clk);
    #2 rst = 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Bounded wait for the termination to settle
  task wait_term(input logic v);
    for (int i = 0; i < 8 && term_on !== v; i++) #25;
    chk("term_on", {3'b000, v}, {3'b000, term_on});
  endtask

  initial begin
    rst = 1'b1;
    cfg = '0;
    cfg.write_latency = 5'h05;
    cfg.wr_cycles = 5'h06;
    n_mismatch = 0;
    n_tests = 0;
    rows = '{'{1'b0, 5'h11, 5'h00, 1'b0, 5'h0c, 1'b0},
      '{1'b0, 5'h11, 5'h00, 1'b0, 5'h0b, 1'b1},
      '{1'b0, 5'h10, 5'h00, 1'b0, 5'h0b, 1'b1},
      '{1'b0, 5'h10, 5'h00, 1'b1, 5'h0a, 1'b0},
      '{1'b0, 5'h10, 5'h00, 1'b1, 5'h09, 1'b1},
      '{1'b0, 5'h09, 5'h00, 1'b0, 5'h10, 1'b0},
      '{1'b0, 5'h09, 5'h00, 1'b0, 5'h0f, 1'b1},
      '{1'b0, 5'h08, 5'h00, 1'b1, 5'h0e, 1'b0},
      '{1'b0, 5'h08, 5'h00, 1'b1, 5'h0d, 1'b1},
      '{1'b0, 5'h02, 5'h00, 1'b0, 5'h0c, 1'b0},
      '{1'b0, 5'h02, 5'h00, 1'b0, 5'h0b, 1'b1},
      '{1'b0, 5'h04, 5'h00, 1'b0, 5'h01, 1'b0},
      '{1'b0, 5'h04, 5'h00, 1'b0, 5'h00, 1'b1},
      '{1'b0, 5'h11, 5'h04, 1'b0, 5'h0b, 1'b1},
      '{1'b1, 5'h00, 5'h00, 1'b0, 5'h04, 1'b0},
      '{1'b1, 5'h00, 5'h00, 1'b0, 5'h03, 1'b1},
      '{1'b1, 5'h11, 5'h00, 1'b0, 5'h05, 1'b1},
      '{1'b1, 5'h11, 5'h00, 1'b0, 5'h06, 1'b0},
      '{1'b1, 5'h11, 5'h00, 1'b1, 5'h04, 1'b0}};
    repeat (5) @(posedge clk);
    #2 rst = 1'b0;
    @(posedge clk) #2;
    chk("outputs", 4'h0, {term_on, level_dq, level_dq_oe, 1'b0});
    chk("viol", 4'h0, viol);
    // Table: spacing before power-down and termination high time
    for (int k = 0; k < 19; k++) begin
      @(posedge clk) #2 cfg.chop_four = rows[k].chop;
      do_reset;
      if (rows[k].term) begin
        i_dpo_ctl_model.term_pulse(rows[k].c, rows[k].n);
        @(posedge ck_pin);
      end else begin
        i_dpo_ctl_model.pd_after(rows[k].c, rows[k].c2, rows[k].n);
      end
      repeat (6) @(posedge clk);
      chk("viol", {rows[k].e & ~rows[k].term, rows[k].e & rows[k].term,
        2'b00}, viol);
    end
    // Frozen power-down: termination follows the pin in clk time
    do_reset;
    #2 cfg.dll_frozen_pd = 1'b1;
    i_dpo_ctl_model.pins(1'b0, 1'b0);
    i_dpo_ctl_model.pins(1'b0, 1'b1);
    wait_term(1'b1);
    i_dpo_ctl_model.pins(1'b0, 1'b0);
    wait_term(1'b0);
    i_dpo_ctl_model.pins(1'b1, 1'b0);
    @(posedge clk) #2 cfg.dll_frozen_pd = 1'b0;
    // Synchronous off lands within a ck period after the latency
    do_reset;
    i_dpo_ctl_model.term_pulse('0, 8);
    chk("term_on", 4'h1, {3'b000, term_on});
    repeat (OFF_LAT - 1) @(posedge ck_pin);
    @(negedge ck_pin);
    chk("term_on", 4'h1, {3'b000, term_on});
    repeat (2) @(posedge ck_pin);
    // Half a period past the reference edge: still on
    #100;
    chk("term_on", 4'h1, {3'b000, term_on});
    @(posedge ck_pin) #10;
    chk("term_on", 4'h0, {3'b000, term_on});
    // Leveling: early drivers and strobe flagged, level echoed back
    for (int j = 0; j < 2; j++) begin
      do_reset;
      @(negedge ck_pin);
      @(posedge clk) #2 cfg.leveling = 1'b1;
      i_dpo_ctl_model.drive_en(j ? 26 : 22, 1'b1);
      i_dpo_ctl_model.strobe(1'b1, 16);
      #100;
      chk("leveling", {2'b11, j ? 2'b00 : 2'b11}, {level_dq_oe, level_dq,
        viol.lvl_strobe_early, viol.lvl_enable_early});
      i_dpo_ctl_model.strobe(1'b0, 1);
      #100;
      chk("level_dq", 4'h0, {3'b000, level_dq});
      i_dpo_ctl_model.drive_en(1, 1'b0);
      @(posedge clk) #2 cfg.leveling = 1'b0;
    end
    complete_run;
  end
endmodule

// [hdl/dpo_pkg.sv]
package dpo_pkg;

  // Clock of the block, in picoseconds
  localparam int CLK_PERIOD_PS = 25000;
  // Default period of the memory clock pin, in picoseconds
  localparam int LINK_PERIOD_PS = 200000;

  // Asynchronous termination switching window, picoseconds
  localparam int ASYNC_TERM_MIN_PS = 1000;
  localparam int ASYNC_TERM_MAX_PS = 9000;
  // Longest time rounds down, never under one cycle
  localparam int ASYNC_TERM_DLY_CYC =
    (ASYNC_TERM_MAX_PS / CLK_PERIOD_PS) > 0 ?
    (ASYNC_TERM_MAX_PS / CLK_PERIOD_PS) : 1;

  // Synchronous turn-off window, tenths of a memory clock period
  localparam int TERM_OFF_MIN_X10 = 3;
  localparam int TERM_OFF_MAX_X10 = 7;
  // Least time rounds up
  localparam int TERM_OFF_MIN_CYC =
    (TERM_OFF_MIN_X10 * LINK_PERIOD_PS + 10 * CLK_PERIOD_PS - 1) /
    (10 * CLK_PERIOD_PS);

  // Leveling output delay, picoseconds; least time rounds up
  localparam int LVL_OUT_DELAY_PS = 900;
  localparam int LVL_OUT_DELAY_CYC =
    (LVL_OUT_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Power-down entry spacing, memory clock cycles
  localparam logic [7:0] WR_TAIL_BURST = 8'h04;
  localparam logic [7:0] WR_TAIL_CHOP = 8'h02;
  localparam logic [7:0] REFRESH_TO_PD_WAIT = 8'h01;
  localparam logic [7:0] AP_EXTRA = 8'h01;

  // Termination high minimums, memory clock cycles
  localparam logic [2:0] TERM_HIGH_SHORT = 3'h4;
  localparam logic [2:0] TERM_HIGH_LONG = 3'h6;

  // Write leveling waits, memory clock cycles
  localparam logic [5:0] LEVELING_FIRST_STROBE_WAIT = 6'h28;
  localparam logic [5:0] LEVELING_STROBE_ENABLE_WAIT = 6'h19;

  // Command pins, sampled on a rising memory clock edge
  typedef struct packed {
    logic write;
    logic write_ap;
    logic refresh;
    logic mode_set;
    logic burst_eight;
  } dpo_cmd_t;

  // Static mode settings
  typedef struct packed {
    logic chop_four;
    logic dll_frozen_pd;
    logic leveling;
    logic [4:0] write_latency;
    logic [4:0] wr_cycles;
  } dpo_cfg_t;

  // Sticky timing violations committed by the controller
  typedef struct packed {
    logic pd_too_early;
    logic term_high_short;
    logic lvl_strobe_early;
    logic lvl_enable_early;
  } dpo_viol_t;

  typedef enum {
    TS_OFF, TS_ASYNC_ON, TS_ON, TS_ASYNC_OFF, TS_LAT, TS_OFF_DLY
  } dpo_term_state_t;

endpackage

// [hdl/dpo_timing_guard.sv]
`timescale 1ns/10ps
module dpo_timing_guard import dpo_pkg::*; #(
  parameter int LINK_PERIOD = LINK_PERIOD_PS,
  parameter int WRITE_RECOVERY_PS = 15000,
  parameter int MODE_UPDATE_CYC = 12,
  parameter int TERM_OFF_LATENCY = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins from the controller
  input wire logic ck_pin,
  input wire logic cke_pin,
  input wire logic term_ctl_pin,
  input wire dpo_cmd_t cmd_pin,
  input wire logic dqs_pin,
  input wire logic dqs_driven_pin,
  input wire dpo_cfg_t cfg_pin,
  // Termination and leveling feedback
  output logic term_on,
  output logic level_dq,
  output logic level_dq_oe,
  // Observed controller violations
  output dpo_viol_t viol
);

  localparam int SW = 5 + $bits(dpo_cmd_t) + $bits(dpo_cfg_t);
  // Rounded recovery count, whole memory cycles
  localparam int WREC_CYC =
    (WRITE_RECOVERY_PS + LINK_PERIOD - 1) / LINK_PERIOD;

  initial begin
    if (WREC_CYC > 31 || MODE_UPDATE_CYC > 255 || MODE_UPDATE_CYC < 1)
      $error("dpo_timing_guard: wait parameter out of range");
    if (TERM_OFF_LATENCY < 1 || TERM_OFF_LATENCY > 15)
      $error("dpo_timing_guard: term off latency out of range");
  end

  // Two-flop synchroniser on every pin
  logic [SW-1:0] sync1_reg, sync2_reg;
  always_ff @(posedge clk) begin
    sync1_reg <= {ck_pin, cke_pin, term_ctl_pin, dqs_pin, dqs_driven_pin,
                  cmd_pin, cfg_pin};
    sync2_reg <= sync1_reg;
  end

  wire ck_s = sync2_reg[SW-1];
  wire cke_s = sync2_reg[SW-2];
  wire term_s = sync2_reg[SW-3];
  wire dqs_s = sync2_reg[SW-4];
  wire dqs_drv_s = sync2_reg[SW-5];
  dpo_cmd_t cmd_s;
  dpo_cfg_t cfg_s;
  assign cmd_s = sync2_reg[$bits(dpo_cfg_t) +: $bits(dpo_cmd_t)];
  assign cfg_s = sync2_reg[$bits(dpo_cfg_t)-1:0];

  // Edge detection on the synchronised pins
  logic ck_prev_reg, dqs_prev_reg, cke_ck_reg, term_ck_reg;
  // Live level loaded in reset too, so no false edge follows it
  always_ff @(posedge clk) begin
    ck_prev_reg <= ck_s;
    dqs_prev_reg <= dqs_s;
  end
  wire ck_rise = ck_s & ~ck_prev_reg;
  wire dqs_rise = dqs_s & ~dqs_prev_reg;
  wire pd_async = cfg_s.dll_frozen_pd & ~cke_s;

  // Levels as seen at the last memory clock edge
  always_ff @(posedge clk) begin
    if (rst) begin
      cke_ck_reg <= 1'b0;
      term_ck_reg <= 1'b0;
    end else if (ck_rise) begin
      cke_ck_reg <= cke_s;
      term_ck_reg <= term_s;
    end
  end
  wire pd_entry = ck_rise & cke_ck_reg & ~cke_s;
  wire term_fall_ck = ck_rise & term_ck_reg & ~term_s;

  // Per-command power-down waits
  wire [7:0] wr_tail = cfg_s.chop_four ? WR_TAIL_CHOP : WR_TAIL_BURST;
  wire [7:0] wl8 = {3'h0, cfg_s.write_latency};
  wire [7:0] wr_wait = wl8 + wr_tail + 8'(WREC_CYC);
  wire [7:0] wra_wait = wl8 + wr_tail + {3'h0, cfg_s.wr_cycles} +
                        AP_EXTRA;
  wire [7:0] mrs_wait = 8'(MODE_UPDATE_CYC);
  wire [7:0] cmd_wait = cmd_s.write ? wr_wait :
                        cmd_s.write_ap ? wra_wait :
                        cmd_s.mode_set ? mrs_wait :
                        cmd_s.refresh ? REFRESH_TO_PD_WAIT : 8'h00;
  logic [7:0] pd_wait_reg;
  wire [7:0] pd_wait_dec = (pd_wait_reg != 8'h00) ? pd_wait_reg - 8'h01 :
                           8'h00;
  // Keep only the longest outstanding wait
  wire [7:0] pd_wait_next = (cmd_wait > pd_wait_dec) ? cmd_wait :
                            pd_wait_dec;

  always_ff @(posedge clk) begin
    if (rst)
      pd_wait_reg <= 8'h00;
    else if (ck_rise)
      pd_wait_reg <= pd_wait_next;
  end

  // Termination high time, counted in memory clocks
  logic [2:0] term_hi_cnt_reg;
  logic term_bl8_reg;
  wire bl8_write = (cmd_s.write | cmd_s.write_ap) & cmd_s.burst_eight &
                   ~cfg_s.chop_four;
  wire [2:0] term_need = term_bl8_reg ? TERM_HIGH_LONG :
                         TERM_HIGH_SHORT;
  always_ff @(posedge clk) begin
    if (rst) begin
      term_hi_cnt_reg <= 3'h0;
      term_bl8_reg <= 1'b0;
    end else if (ck_rise) begin
      if (!term_s) begin
        term_hi_cnt_reg <= 3'h0;
        term_bl8_reg <= 1'b0;
      end else begin
        if (term_hi_cnt_reg != 3'h7)
          term_hi_cnt_reg <= term_hi_cnt_reg + 3'h1;
        if (bl8_write)
          term_bl8_reg <= 1'b1;
      end
    end
  end

  // Memory clocks since leveling was enabled, saturating
  logic [5:0] lvl_cnt_reg;
  always_ff @(posedge clk) begin
    if (rst || !cfg_s.leveling)
      lvl_cnt_reg <= 6'h00;
    else if (ck_rise && lvl_cnt_reg != 6'h3f)
      lvl_cnt_reg <= lvl_cnt_reg + 6'h01;
  end

  // Violation detection; flags stay set until reset
  dpo_viol_t viol_next;
  always_comb begin
    viol_next = viol;
    // Entry exactly N rises after a command is legal; same rise is not
    if (pd_entry && (pd_wait_dec != 8'h00 || cmd_wait != 8'h00))
      viol_next.pd_too_early = 1'b1;
    if (term_fall_ck && term_hi_cnt_reg < term_need)
      viol_next.term_high_short = 1'b1;
    if (cfg_s.leveling && dqs_rise &&
        lvl_cnt_reg < LEVELING_FIRST_STROBE_WAIT)
      viol_next.lvl_strobe_early = 1'b1;
    if (cfg_s.leveling && dqs_drv_s &&
        lvl_cnt_reg < LEVELING_STROBE_ENABLE_WAIT)
      viol_next.lvl_enable_early = 1'b1;
  end
  always_ff @(posedge clk) begin
    if (rst)
      viol <= '0;
    else
      viol <= viol_next;
  end

  // Leveling feedback: clock level caught on each strobe rise
  always_ff @(posedge clk) begin
    if (rst) begin
      level_dq <= 1'b0;
      level_dq_oe <= 1'b0;
    end else begin
      level_dq_oe <= cfg_s.leveling;
      if (cfg_s.leveling && dqs_rise)
        level_dq <= ck_s;
    end
  end

  // Termination switching; async path needs no memory clock at all
  dpo_term_state_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      TS_OFF: begin
        if (pd_async && term_s) begin
          st_next = TS_ASYNC_ON;
          cnt_next = 4'(ASYNC_TERM_DLY_CYC - 1);
        end else if (!pd_async && ck_rise && term_s)
          st_next = TS_ON;
      end
      TS_ASYNC_ON: begin
        if (cnt_reg == 4'h0)
          st_next = TS_ON;
        else
          cnt_next = cnt_reg - 4'h1;
      end
      TS_ON: begin
        if (pd_async && !term_s) begin
          st_next = TS_ASYNC_OFF;
          cnt_next = 4'(ASYNC_TERM_DLY_CYC - 1);
        end else if (!pd_async && ck_rise && !term_s) begin
          st_next = TS_LAT;
          cnt_next = 4'(TERM_OFF_LATENCY - 1);
        end
      end
      TS_ASYNC_OFF: begin
        if (cnt_reg == 4'h0)
          st_next = TS_OFF;
        else
          cnt_next = cnt_reg - 4'h1;
      end
      TS_LAT: begin
        if (ck_rise) begin
          if (cnt_reg == 4'h0) begin
            st_next = TS_OFF_DLY;
            cnt_next = 4'(TERM_OFF_MIN_CYC - 1);
          end else
            cnt_next = cnt_reg - 4'h1;
        end
      end
      TS_OFF_DLY: begin
        if (cnt_reg == 4'h0)
          st_next = TS_OFF;
        else
          cnt_next = cnt_reg - 4'h1;
      end
      default: st_next = TS_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= TS_OFF;
      cnt_reg <= 4'h0;
      term_on <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      term_on <= (st_next != TS_OFF) && (st_next != TS_ASYNC_ON);
    end
  end

  a_async_term_on: assert property (@(posedge clk) disable iff (rst)
    (st_reg == TS_OFF && pd_async && term_s) |=> !term_on ##1 term_on)
    else $error("async termination on delay wrong");
  a_async_term_off: assert property (@(posedge clk) disable iff (rst)
    (st_reg == TS_ON && pd_async && !term_s) |=> term_on ##1 !term_on)
    else $error("async termination off delay wrong");
  a_sync_term_off: assert property (@(posedge clk) disable iff (rst)
    (st_reg == TS_LAT && ck_rise && cnt_reg == 4'h0)
      |=> term_on [*3] ##1 !term_on)
    else $error("sync termination off time wrong");
  a_level_dq_value: assert property (@(posedge clk) disable iff (rst)
    (cfg_s.leveling && dqs_rise) |=> level_dq == $past(ck_s))
    else $error("leveling feedback level wrong");
  a_level_dq_drive: assert property (@(posedge clk) disable iff (rst)
    $rose(cfg_s.leveling) |=> level_dq_oe)
    else $error("leveling feedback not driven");
  a_wait_rounded: assert property (@(posedge clk) disable iff (rst)
    (ck_rise && cmd_s.write)
      |=> pd_wait_reg >= $past(wl8) + 8'(WREC_CYC) + 8'h02)
    else $error("write wait shorter than rounded count");
  a_pd_entry_early: assert property (@(posedge clk) disable iff (rst)
    (pd_entry && pd_wait_dec != 8'h00) |=> viol.pd_too_early)
    else $error("early power-down entry not flagged");

endmodule
